// ==== rtl/prf_regfile.v ====
// register file: data/address registers, stack pointers, status word, pointer, debug access
// assumes one-cycle core strobes on core_clk_i and a vector port answering with vec_ack_i
//
// Contract
// - data registers take bit, byte, word, long writes and serve as index
// - first two data registers hold configuration straps after reset
// - address registers take word (sign-extended) and long writes, serve as index/base
// - two physical stack pointers; active one follows privilege mode
// - debug codes 0x6F/0x4F reach active, 0xE0 the alternate stack pointer
// - user stack moves reach the alternate pointer; all else uses active
// - reset processing loads supervisor stack pointer from address zero
// - flag byte is status word low byte; extend feeds multiprecision math
// - extend copies carry for arithmetic, else kept or set by instruction
// - negative flag copies result msb
// - zero flag set when result is zero, except multiprecision ops, which only clear it
// - overflow flag set when result does not fit operand size
// - carry flag set on carry out or borrow at operand msb
// - instruction pointer increments, reloads, and bases pc-relative addresses
// - reset processing loads instruction pointer from address four
// - debug 0xEE/0xCE read/write status word, 0xEF reads instruction pointer
// - control register move carries a 12-bit number selecting its target
// - multiply-accumulate debug codes are mapped only when that unit is present; no such registers are held
// - privilege bit picks model; supervisor-only registers refused in user mode
`include "prf_map.vh"
`default_nettype none

module prf_regfile #(
  parameter MAC_PRESENT = 0
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // configuration straps for the first two data registers
  input wire [31:0] cfg_word0_i,
  input wire [31:0] cfg_word1_i,
  // reset vector fetch
  output reg vec_req_o,
  output reg [23:0] vec_addr_o,
  input wire vec_ack_i,
  input wire [31:0] vec_data_i,
  output reg core_ready_o,
  // register writes from the core
  input wire core_wr_en_i,
  input wire [3:0] core_wr_idx_i,
  input wire [1:0] core_wr_size_i,
  input wire [31:0] core_wr_data_i,
  input wire core_bit_en_i,
  input wire [2:0] core_bit_reg_i,
  input wire [4:0] core_bit_num_i,
  input wire [1:0] core_bit_op_i,
  // register reads (operand and index)
  input wire [3:0] core_rd_idx_i,
  output reg [31:0] core_rd_data_o,
  input wire [3:0] core_ix_idx_i,
  output reg [31:0] core_ix_data_o,
  // user stack moves
  input wire core_usp_wr_i,
  input wire [31:0] core_usp_data_i,
  output reg [31:0] core_usp_data_o,
  // flag updates
  input wire core_flag_en_i,
  input wire core_flag_arith_i,
  input wire core_flag_sub_i,
  input wire core_flag_usex_i,
  input wire [1:0] core_flag_size_i,
  input wire [31:0] core_op_a_i,
  input wire [31:0] core_op_b_i,
  output reg [31:0] core_alu_res_o,
  // status word writes
  input wire core_ccr_wr_i,
  input wire core_sr_wr_i,
  input wire [15:0] core_sr_data_i,
  output reg [15:0] sr_o,
  output reg priv_err_o,
  // control register move
  input wire core_control_register_move_en_i,
  input wire [11:0] core_control_register_move_num_i,
  input wire [31:0] core_control_register_move_data_i,
  output reg control_register_move_vbr_wr_o,
  output reg control_register_move_cpucr_wr_o,
  output reg [31:0] control_register_move_data_o,
  // instruction pointer
  input wire core_pc_inc_i,
  input wire [3:0] core_pc_inc_amt_i,
  input wire core_pc_load_i,
  input wire [31:0] core_pc_data_i,
  input wire [31:0] core_pcrel_disp_i,
  output reg [31:0] pc_o,
  output reg [31:0] pcrel_addr_o,
  // debug port
  input wire dbg_valid_i,
  input wire [7:0] dbg_code_i,
  input wire [31:0] dbg_wdata_i,
  output reg dbg_ack_o,
  output reg dbg_err_o,
  output reg [31:0] dbg_rdata_o
);
  localparam ST_FETCH_SSP = 2'b00;
  localparam ST_FETCH_PC = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [31:0] dreg_q [0:7];
  reg [31:0] areg_q [0:6];
  reg [31:0] sp_q [0:1];
  reg act_q;
  reg [15:0] sr_q;
  reg [23:0] pc_q;
  reg [1:0] st_q;
  reg strap_q;
  wire [31:0] alu_res;
  wire [4:0] alu_flags;
  wire is_super = sr_q[`PRF_SR_S_BIT];
  integer i;
  // merge a sized write into an old value; address registers sign-extend words
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nv;
    input [1:0] size;
    input addr;
    begin
      if (addr) begin
        merge = (size == `PRF_SZ_WORD) ? {{16{nv[15]}}, nv[15:0]} : nv;
      end else begin
        case (size)
          `PRF_SZ_BYTE: merge = {old[31:8], nv[7:0]};
          `PRF_SZ_WORD: merge = {old[31:16], nv[15:0]};
          default: merge = nv;
        endcase
      end
    end
  endfunction
  // read by register index; 15 is the active stack pointer
  function [31:0] rd_reg;
    input [3:0] idx;
    begin
      if (!idx[3]) begin
        rd_reg = dreg_q[idx[2:0]];
      end else if (idx[2:0] == 3'h7) begin
        rd_reg = sp_q[act_q];
      end else begin
        rd_reg = areg_q[idx[2:0]];
      end
    end
  endfunction
  prf_flags u_flags (
    .a_i(core_op_a_i),
    .b_i(core_op_b_i),
    .size_i(core_flag_size_i),
    .arith_i(core_flag_arith_i),
    .sub_i(core_flag_sub_i),
    .use_x_i(core_flag_usex_i),
    .flags_i(sr_q[4:0]),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );
  // debug decode
  wire dbg_ld = dbg_valid_i && (dbg_code_i[7:4] == 4'h6 || dbg_code_i[7:4] == 4'he);
  wire dbg_st = dbg_valid_i && (dbg_code_i[7:4] == 4'h4 || dbg_code_i[7:4] == 4'hc);
  wire [7:0] dbg_key = dbg_code_i | 8'h20;
  wire dbg_gpr = (dbg_key[7:4] == 4'h6);
  wire dbg_osp = (dbg_key == `PRF_CMD_LD_OSP);
  wire dbg_sr = (dbg_key == `PRF_CMD_LD_SR);
  wire dbg_pc = (dbg_key == `PRF_CMD_LD_PC);
  wire dbg_mac = (dbg_key >= `PRF_CMD_LD_MAC) && (dbg_key <= `PRF_CMD_LD_MAC + 8'h02);
  wire dbg_hit = dbg_gpr || dbg_osp || dbg_sr || dbg_pc;
  // supervisor-only requests refused in user mode
  wire usp_ok = core_usp_wr_i && is_super;
  wire sr_ok = core_sr_wr_i && is_super;
  wire control_register_move_ok = core_control_register_move_en_i && is_super;
  wire [15:0] sr_wr_val = {core_sr_data_i[15:8], core_sr_data_i[7:0] & `PRF_CCR_MASK};
  wire [15:0] dbg_sr_val = {dbg_wdata_i[15:8], dbg_wdata_i[7:0] & `PRF_CCR_MASK};
  reg [15:0] sr_d;
  always @* begin
    sr_d = sr_q;
    if (core_flag_en_i) begin
      sr_d[4:0] = alu_flags;
    end
    if (core_ccr_wr_i) begin
      sr_d[7:0] = core_sr_data_i[7:0] & `PRF_CCR_MASK;
    end
    if (sr_ok) begin
      sr_d = sr_wr_val;
    end
    if (dbg_st && dbg_sr) begin
      sr_d = dbg_sr_val;
    end
  end
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q <= ST_FETCH_SSP;
      strap_q <= 1'b1;
      act_q <= 1'b0;
      sr_q <= `PRF_SR_RESET;
      pc_q <= 24'h000000;
      sp_q[0] <= 32'h00000000;
      sp_q[1] <= 32'h00000000;
      for (i = 0; i < 8; i = i + 1) begin
        dreg_q[i] <= 32'h00000000;
      end
      for (i = 0; i < 7; i = i + 1) begin
        areg_q[i] <= 32'h00000000;
      end
      vec_req_o <= 1'b0;
      vec_addr_o <= `PRF_VEC_SSP_ADDR;
      core_ready_o <= 1'b0;
      core_rd_data_o <= 32'h00000000;
      core_ix_data_o <= 32'h00000000;
      core_usp_data_o <= 32'h00000000;
      core_alu_res_o <= 32'h00000000;
      sr_o <= `PRF_SR_RESET;
      priv_err_o <= 1'b0;
      control_register_move_vbr_wr_o <= 1'b0;
      control_register_move_cpucr_wr_o <= 1'b0;
      control_register_move_data_o <= 32'h00000000;
      pc_o <= 32'h00000000;
      pcrel_addr_o <= 32'h00000000;
      dbg_ack_o <= 1'b0;
      dbg_err_o <= 1'b0;
      dbg_rdata_o <= 32'h00000000;
    end else begin
      // straps are caught on the first edge after reset release
      strap_q <= 1'b0;
      if (strap_q) begin
        dreg_q[0] <= cfg_word0_i;
        dreg_q[1] <= cfg_word1_i;
      end
      // reset exception vector fetch
      case (st_q)
        ST_FETCH_SSP: begin
          vec_req_o <= ~vec_ack_i;
          vec_addr_o <= `PRF_VEC_SSP_ADDR;
          if (vec_ack_i) begin
            sp_q[act_q] <= vec_data_i;
            vec_addr_o <= `PRF_VEC_PC_ADDR;
            vec_req_o <= 1'b1;
            st_q <= ST_FETCH_PC;
          end
        end
        ST_FETCH_PC: begin
          if (vec_ack_i) begin
            pc_q <= vec_data_i[23:0];
            vec_req_o <= 1'b0;
            core_ready_o <= 1'b1;
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (core_pc_load_i) begin
            pc_q <= core_pc_data_i[23:0];
          end else if (core_pc_inc_i) begin
            pc_q <= pc_q + {20'h00000, core_pc_inc_amt_i};
          end
        end
        default: begin
          st_q <= ST_FETCH_SSP;
        end
      endcase
      // core register writes
      if (core_wr_en_i) begin
        if (!core_wr_idx_i[3]) begin
          dreg_q[core_wr_idx_i[2:0]] <= merge(dreg_q[core_wr_idx_i[2:0]], core_wr_data_i,
                                              core_wr_size_i, 1'b0);
        end else if (core_wr_idx_i[2:0] == 3'h7) begin
          sp_q[act_q] <= merge(sp_q[act_q], core_wr_data_i, core_wr_size_i, 1'b1);
        end else begin
          areg_q[core_wr_idx_i[2:0]] <= merge(areg_q[core_wr_idx_i[2:0]], core_wr_data_i,
                                              core_wr_size_i, 1'b1);
        end
      end
      if (core_bit_en_i) begin
        case (core_bit_op_i)
          `PRF_BIT_SET: dreg_q[core_bit_reg_i][core_bit_num_i] <= 1'b1;
          `PRF_BIT_CLR: dreg_q[core_bit_reg_i][core_bit_num_i] <= 1'b0;
          `PRF_BIT_CHG: dreg_q[core_bit_reg_i][core_bit_num_i] <=
                        ~dreg_q[core_bit_reg_i][core_bit_num_i];
          default: dreg_q[core_bit_reg_i][core_bit_num_i] <=
                   dreg_q[core_bit_reg_i][core_bit_num_i];
        endcase
      end
      if (usp_ok) begin
        sp_q[~act_q] <= core_usp_data_i;
      end
      // debug writes land after core writes and so take priority
      if (dbg_st && dbg_gpr) begin
        if (!dbg_code_i[3]) begin
          dreg_q[dbg_code_i[2:0]] <= dbg_wdata_i;
        end else if (dbg_code_i[2:0] == 3'h7) begin
          sp_q[act_q] <= dbg_wdata_i;
        end else begin
          areg_q[dbg_code_i[2:0]] <= dbg_wdata_i;
        end
      end
      if (dbg_st && dbg_osp) begin
        sp_q[~act_q] <= dbg_wdata_i;
      end
      if (dbg_st && dbg_pc) begin
        pc_q <= dbg_wdata_i[23:0];
      end
      // a change of privilege swaps the roles of the two stack pointers
      sr_q <= sr_d;
      if (sr_d[`PRF_SR_S_BIT] != sr_q[`PRF_SR_S_BIT]) begin
        act_q <= ~act_q;
      end
      // registered results
      core_rd_data_o <= rd_reg(core_rd_idx_i);
      core_ix_data_o <= rd_reg(core_ix_idx_i);
      core_usp_data_o <= is_super ? sp_q[~act_q] : 32'h00000000;
      core_alu_res_o <= alu_res;
      sr_o <= sr_q;
      pc_o <= {8'h00, pc_q};
      pcrel_addr_o <= {8'h00, pc_q + core_pcrel_disp_i[23:0]};
      priv_err_o <= (core_usp_wr_i || core_sr_wr_i || core_control_register_move_en_i) && !is_super;
      control_register_move_vbr_wr_o <= control_register_move_ok && (core_control_register_move_num_i == `PRF_RC_VBR);
      control_register_move_cpucr_wr_o <= control_register_move_ok && (core_control_register_move_num_i == `PRF_RC_CPUCR);
      control_register_move_data_o <= control_register_move_ok ? core_control_register_move_data_i : control_register_move_data_o;
      // debug answer one cycle after the command
      dbg_ack_o <= dbg_ld || dbg_st;
      // multiply-accumulate codes are unmapped when that unit is absent
      dbg_err_o <= (dbg_ld || dbg_st) && !dbg_hit && !(dbg_mac && MAC_PRESENT != 0);
      if (dbg_ld) begin
        if (dbg_gpr) begin
          dbg_rdata_o <= rd_reg(dbg_code_i[3:0]);
        end else if (dbg_osp) begin
          dbg_rdata_o <= sp_q[~act_q];
        end else if (dbg_sr) begin
          dbg_rdata_o <= {16'h0000, sr_q};
        end else if (dbg_pc) begin
          dbg_rdata_o <= {8'h00, pc_q};
        end else begin
          dbg_rdata_o <= 32'h00000000;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== rtl/prf_map.vh ====
// constants of the programmer register file: debug codes, flag bits, sizes, vectors
// included by the register file and the flag unit; definitions only
`ifndef PRF_MAP_VH
`define PRF_MAP_VH

// debug port load/store codes
`define PRF_CMD_LD_D 8'h60
`define PRF_CMD_ST_D 8'h40
`define PRF_CMD_LD_A 8'h68
`define PRF_CMD_ST_A 8'h48
`define PRF_CMD_LD_SP 8'h6f
`define PRF_CMD_ST_SP 8'h4f
`define PRF_CMD_LD_OSP 8'he0
`define PRF_CMD_ST_OSP 8'hc0
`define PRF_CMD_LD_MAC 8'he4
`define PRF_CMD_ST_MAC 8'hc4
`define PRF_CMD_LD_SR 8'hee
`define PRF_CMD_ST_SR 8'hce
`define PRF_CMD_LD_PC 8'hef
`define PRF_CMD_ST_PC 8'hcf

// status word
`define PRF_SR_RESET 16'h2700
`define PRF_SR_S_BIT 13
`define PRF_CCR_MASK 8'h1f
`define PRF_CCR_X 4
`define PRF_CCR_N 3
`define PRF_CCR_Z 2
`define PRF_CCR_V 1
`define PRF_CCR_C 0

// operand sizes
`define PRF_SZ_BYTE 2'b00
`define PRF_SZ_WORD 2'b01
`define PRF_SZ_LONG 2'b10

// bit operations
`define PRF_BIT_SET 2'b00
`define PRF_BIT_CLR 2'b01
`define PRF_BIT_CHG 2'b10

// reset vectors and address width
`define PRF_PC_W 24
`define PRF_VEC_SSP_ADDR 24'h000000
`define PRF_VEC_PC_ADDR 24'h000004

// control register numbers
`define PRF_RC_VBR 12'h801
`define PRF_RC_CPUCR 12'h802

`endif

// ==== rtl/prf_flags.v ====
// flag unit: add/subtract or pass-through with result flags at byte, word or long size
// purely combinational; the register file latches its results
`include "prf_map.vh"
`default_nettype none

module prf_flags (
  // operands
  input wire [31:0] a_i,
  input wire [31:0] b_i,
  input wire [1:0] size_i,
  // operation
  input wire arith_i,
  input wire sub_i,
  input wire use_x_i,
  // current flags
  input wire [4:0] flags_i,
  // results
  output reg [31:0] res_o,
  output reg [4:0] flags_o
);
  reg [31:0] mask;
  reg [31:0] bb;
  reg [32:0] sum;
  reg cin;
  reg carry;
  reg msb_a;
  reg msb_b;
  reg msb_r;
  reg zero;
  integer w;

  always @* begin
    case (size_i)
      `PRF_SZ_BYTE: w = 8;
      `PRF_SZ_WORD: w = 16;
      default: w = 32;
    endcase
    mask = (w == 32) ? 32'hffffffff : ((32'h00000001 << w) - 32'h00000001);
    bb = (sub_i ? ~b_i : b_i) & mask;
    // extend flag feeds multiprecision add/subtract
    cin = sub_i ^ (use_x_i & flags_i[`PRF_CCR_X]);
    sum = {1'b0, a_i & mask} + {1'b0, bb} + {32'h00000000, cin};
    carry = sum[w];
    msb_a = a_i[w-1];
    msb_b = bb[w-1];
    res_o = arith_i ? (sum[31:0] & mask) : (a_i & mask);
    msb_r = res_o[w-1];
    zero = (res_o == 32'h00000000);
    flags_o = flags_i;
    flags_o[`PRF_CCR_N] = msb_r;
    // multiprecision ops only clear zero, never set it
    flags_o[`PRF_CCR_Z] = (arith_i && use_x_i) ? (flags_i[`PRF_CCR_Z] & zero) : zero;
    if (arith_i) begin
      flags_o[`PRF_CCR_V] = (msb_a == msb_b) && (msb_r != msb_a);
      flags_o[`PRF_CCR_C] = sub_i ? ~carry : carry;
      flags_o[`PRF_CCR_X] = sub_i ? ~carry : carry;
    end else begin
      flags_o[`PRF_CCR_V] = 1'b0;
      flags_o[`PRF_CCR_C] = 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== sim/prf_vec_mem.sv ====
// vector memory model on the register file's reset vector port
// answers each read after lat_i waiting cycles; the data lines toggle while not answering
`default_nettype none
module prf_vec_mem #(
  parameter logic [31:0] SSP_VAL = 32'h0080_1000,
  parameter logic [31:0] PC_VAL = 32'h0000_0410
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // vector port
  input wire logic req_i,
  input wire logic [23:0] addr_i,
  input wire logic [3:0] lat_i,
  output var logic ack_o,
  output var logic [31:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic go;
  assign go = !reset_i && req_i && !ack_o && wait_q >= lat_i;
  always @(posedge core_clk_i) begin
    if (reset_i || !req_i || ack_o) begin
      wait_q <= 4'h0;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
    ack_o <= go;
    if (reset_i) begin
      data_o <= 32'h5a5a_5a5a;
    end else if (go) begin
      data_o <= (addr_i == 24'h0) ? SSP_VAL : PC_VAL;
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule
`default_nettype wire

// ==== sim/prf_regfile_properties.sv ====
// checker for the register file: debug answers, vector fetch order, read-as-zero fields
// bound to prf_regfile, sees its ports only
`default_nettype none
module prf_regfile_chk #(
  parameter MAC_PRESENT = 0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // vector fetch
  input wire logic vec_req_o,
  input wire logic [23:0] vec_addr_o,
  input wire logic vec_ack_i,
  input wire logic [31:0] vec_data_i,
  input wire logic core_ready_o,
  // core status updates
  input wire logic core_flag_en_i,
  input wire logic core_flag_arith_i,
  input wire logic core_ccr_wr_i,
  input wire logic core_sr_wr_i,
  input wire logic [15:0] sr_o,
  input wire logic [31:0] pc_o,
  // debug port
  input wire logic dbg_valid_i,
  input wire logic [7:0] dbg_code_i,
  input wire logic dbg_ack_o,
  input wire logic dbg_err_o,
  input wire logic [31:0] dbg_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_ack_next; dbg_valid_i |=> dbg_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("debug ack missing");
  property p_ack_cause; dbg_ack_o |-> $past(dbg_valid_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("debug ack unasked");
  property p_flag_hi; sr_o[7:5] == 3'h0; endproperty
  a_flag_hi: assert property (p_flag_hi) else $error("flag byte top bits set");
  property p_pc_hi; pc_o[31:24] == 8'h0; endproperty
  a_pc_hi: assert property (p_pc_hi) else $error("pointer top byte set");
  property p_ssp_first;
    vec_req_o && vec_ack_i && vec_addr_o == 24'h0 |=>
      vec_req_o && vec_addr_o == 24'h4 && !core_ready_o;
  endproperty
  a_ssp_first: assert property (p_ssp_first) else $error("vector order wrong");
  property p_pc_vec;
    vec_req_o && vec_ack_i && vec_addr_o == 24'h4 |=>
      !vec_req_o && core_ready_o ##1 pc_o[23:0] == $past(vec_data_i[23:0], 2);
  endproperty
  a_pc_vec: assert property (p_pc_vec) else $error("pointer vector not loaded");
  property p_x_copies_c;
    core_flag_en_i && core_flag_arith_i ##1
      !(core_flag_en_i || core_ccr_wr_i || core_sr_wr_i || dbg_valid_i)
      |=> sr_o[4] == sr_o[0];
  endproperty
  a_x_copies_c: assert property (p_x_copies_c) else $error("extend differs from carry");
  property p_sr_read;
    dbg_valid_i && dbg_code_i == 8'hee |=> dbg_rdata_o[31:16] == 16'h0 && dbg_rdata_o[7:5] == 3'h0;
  endproperty
  a_sr_read: assert property (p_sr_read) else $error("status read bad");
  property p_mac_absent;
    MAC_PRESENT == 0 && dbg_valid_i && dbg_code_i inside {8'he4, 8'he5, 8'he6}
      |=> dbg_err_o && dbg_ack_o && dbg_rdata_o == 32'h0;
  endproperty
  a_mac_absent: assert property (p_mac_absent) else $error("absent unit answered");
  c_err: cover property (dbg_ack_o && dbg_err_o);
  c_ready: cover property ($rose(core_ready_o));
  c_arith: cover property (core_flag_en_i && core_flag_arith_i);
endmodule
bind prf_regfile prf_regfile_chk #(.MAC_PRESENT(MAC_PRESENT)) u_chk (.core_clk_i, .reset_i,
  .vec_req_o, .vec_addr_o, .vec_ack_i, .vec_data_i, .core_ready_o, .core_flag_en_i,
  .core_flag_arith_i, .core_ccr_wr_i, .core_sr_wr_i, .sr_o, .pc_o, .dbg_valid_i,
  .dbg_code_i, .dbg_ack_o, .dbg_err_o, .dbg_rdata_o);
`default_nettype wire

// ==== sim/tb.sv ====
// testbench for the register file: debug rows, reset vectors, flags, stack swap, core writes
// vector memory model answers the fetch port; straps are fixed words
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SSP_VAL = 32'h0080_1000;
  localparam logic [31:0] PC_VAL = 32'h0000_0410;
  localparam logic [31:0] CFG0 = 32'h1357_9bdf;
  localparam logic [31:0] CFG1 = 32'h2468_ace0;
  typedef struct packed {logic [7:0] st; logic [7:0] ld; logic [31:0] w; logic [31:0] e;} prf_row_t;
  prf_row_t rows [6] = '{
    '{8'h40, 8'h60, 32'hdead_beef, 32'hdead_beef},
    '{8'h4e, 8'h6e, 32'h8000_0001, 32'h8000_0001},
    '{8'h4f, 8'h6f, 32'h0000_a000, 32'h0000_a000},
    '{8'hc0, 8'he0, 32'h0000_b000, 32'h0000_b000},
    '{8'hce, 8'hee, 32'hffff_27ff, 32'h0000_271f},
    '{8'hcf, 8'hef, 32'hff12_3456, 32'h0012_3456}};
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] lat = 4'h3;
  logic vec_req, vec_ack, ready, priv_err, vbr_wr, cpucr_wr, d_ack, d_err, ack, err, hit;
  logic [23:0] vec_addr;
  logic [31:0] vec_data, rd_o, ix_o, usp_o, alu_o, mv_o, pc_o, rel_o, d_rd, rd;
  logic [15:0] sr_o;
  logic wr_en = 1'b0, bit_en = 1'b0, usp_wr = 1'b0, fl_en = 1'b0, fl_ar = 1'b0, fl_sub = 1'b0;
  logic fl_x = 1'b0, ccr_wr = 1'b0, sr_wr = 1'b0, mv_en = 1'b0, pc_inc = 1'b0, pc_ld = 1'b0;
  logic dv = 1'b0;
  logic [3:0] wr_idx = 4'h0, rd_idx = 4'h0, inc_amt = 4'h0;
  logic [1:0] wr_sz = 2'h0, bit_op = 2'h0, fl_sz = 2'h0;
  logic [2:0] bit_reg = 3'h0;
  logic [4:0] bit_num = 5'h0;
  logic [11:0] mv_num = 12'h0;
  logic [7:0] code = 8'h0;
  logic [15:0] sr_d = 16'h0;
  logic [31:0] wr_d = 32'h0, usp_d = 32'h0, op_a = 32'h0, op_b = 32'h0, mv_d = 32'h0;
  logic [31:0] pc_d = 32'h0, disp = 32'h0, wd = 32'h0;
  int failures = 0;
  int samples_checked = 0;

  prf_vec_mem #(.SSP_VAL(SSP_VAL), .PC_VAL(PC_VAL)) u_mem (.core_clk_i, .reset_i,
    .req_i(vec_req), .addr_i(vec_addr), .lat_i(lat), .ack_o(vec_ack), .data_o(vec_data));
  prf_regfile u_dut (.core_clk_i, .reset_i, .cfg_word0_i(CFG0), .cfg_word1_i(CFG1),
    .vec_req_o(vec_req), .vec_addr_o(vec_addr), .vec_ack_i(vec_ack), .vec_data_i(vec_data),
    .core_ready_o(ready), .core_wr_en_i(wr_en), .core_wr_idx_i(wr_idx), .core_wr_size_i(wr_sz),
    .core_wr_data_i(wr_d), .core_bit_en_i(bit_en), .core_bit_reg_i(bit_reg),
    .core_bit_num_i(bit_num), .core_bit_op_i(bit_op), .core_rd_idx_i(rd_idx),
    .core_rd_data_o(rd_o), .core_ix_idx_i(rd_idx), .core_ix_data_o(ix_o),
    .core_usp_wr_i(usp_wr), .core_usp_data_i(usp_d), .core_usp_data_o(usp_o),
    .core_flag_en_i(fl_en), .core_flag_arith_i(fl_ar), .core_flag_sub_i(fl_sub),
    .core_flag_usex_i(fl_x), .core_flag_size_i(fl_sz), .core_op_a_i(op_a), .core_op_b_i(op_b),
    .core_alu_res_o(alu_o), .core_ccr_wr_i(ccr_wr), .core_sr_wr_i(sr_wr),
    .core_sr_data_i(sr_d), .sr_o(sr_o), .priv_err_o(priv_err), .core_control_register_move_en_i(mv_en),
    .core_control_register_move_num_i(mv_num), .core_control_register_move_data_i(mv_d), .control_register_move_vbr_wr_o(vbr_wr),
    .control_register_move_cpucr_wr_o(cpucr_wr), .control_register_move_data_o(mv_o), .core_pc_inc_i(pc_inc),
    .core_pc_inc_amt_i(inc_amt), .core_pc_load_i(pc_ld), .core_pc_data_i(pc_d),
    .core_pcrel_disp_i(disp), .pc_o(pc_o), .pcrel_addr_o(rel_o), .dbg_valid_i(dv),
    .dbg_code_i(code), .dbg_wdata_i(wd), .dbg_ack_o(d_ack), .dbg_err_o(d_err),
    .dbg_rdata_o(d_rd));

  always #10 core_clk_i = ~core_clk_i;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one debug request; the answer is taken in the cycle after the request edge
  task automatic dbg(input logic [7:0] c, input logic [31:0] w);
    @(posedge core_clk_i);
    dv <= 1'b1;
    code <= c;
    wd <= w;
    @(posedge core_clk_i);
    dv <= 1'b0;
    #1;
    ack = d_ack;
    err = d_err;
    rd = d_rd;
    chk("dbg_ack", 32'h1, {31'h0, ack});
  endtask
  task automatic boot(input logic [3:0] l);
    @(posedge core_clk_i);
    lat <= l;
    reset_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    #1;
    chk("sr_reset", 32'h2700, {16'h0, sr_o});
    for (int i = 0; i < 40 && ready !== 1'b1; i++) @(posedge core_clk_i);
    #1;
    chk("ready", 32'h1, {31'h0, ready});
    dbg(8'h60, 32'h0);
    chk("d0", CFG0, rd);
    dbg(8'h61, 32'h0);
    chk("d1", CFG1, rd);
    dbg(8'h6f, 32'h0);
    chk("ssp", SSP_VAL, rd);
    dbg(8'hef, 32'h0);
    chk("pc", PC_VAL, rd);
  endtask
  task automatic flag(input logic ar, input logic sb, input logic [1:0] s,
                      input logic [31:0] a, input logic [31:0] b, input logic [4:0] e);
    @(posedge core_clk_i);
    fl_en <= 1'b1;
    fl_ar <= ar;
    fl_sub <= sb;
    fl_sz <= s;
    op_a <= a;
    op_b <= b;
    @(posedge core_clk_i);
    fl_en <= 1'b0;
    dbg(8'hee, 32'h0);
    chk("flags", {27'h0, e}, {24'h0, rd[7:0]});
  endtask
  task automatic cw(input logic [3:0] i, input logic [1:0] s, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_sz <= s;
    wr_d <= d;
    rd_idx <= i;
    @(posedge core_clk_i);
    wr_en <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  // watches a one-cycle pulse over the three cycles after its cause
  task automatic catch(input logic [1:0] sel);
    hit = 1'b0;
    repeat (3) begin
      #1 hit = hit | (sel[1] ? cpucr_wr : (sel[0] ? vbr_wr : priv_err));
      @(posedge core_clk_i);
    end
  endtask

  initial begin
    boot(4'h3);
    foreach (rows[i]) begin
      dbg(rows[i].st, rows[i].w);
      dbg(rows[i].ld, 32'h0);
      chk("row", rows[i].e, rd);
      chk("row_err", 32'h0, {31'h0, err});
    end
    flag(1'b0, 1'b0, 2'b10, 32'h8000_0000, 32'h0, 5'h18);
    flag(1'b1, 1'b0, 2'b10, 32'hffff_ffff, 32'h1, 5'h15);
    flag(1'b1, 1'b0, 2'b10, 32'h7fff_ffff, 32'h1, 5'h0a);
    chk("alu_res", 32'h8000_0000, alu_o);
    flag(1'b1, 1'b0, 2'b00, 32'h0000_0180, 32'h80, 5'h17);
    flag(1'b1, 1'b1, 2'b01, 32'h0000_0005, 32'h5, 5'h04);
    dbg(8'he4, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    @(posedge core_clk_i);
    sr_wr <= 1'b1;
    sr_d <= 16'h0000;
    @(posedge core_clk_i);
    sr_wr <= 1'b0;
    dbg(8'h6f, 32'h0);
    chk("sp_user", 32'h0000_b000, rd);
    dbg(8'he0, 32'h0);
    chk("sp_alt", 32'h0000_a000, rd);
    chk("usp_hidden", 32'h0, usp_o);
    @(posedge core_clk_i);
    usp_wr <= 1'b1;
    usp_d <= 32'h1111_0000;
    @(posedge core_clk_i);
    usp_wr <= 1'b0;
    catch(2'b00);
    chk("priv_err", 32'h1, {31'h0, hit});
    dbg(8'hce, 32'h0000_2700);
    dbg(8'he0, 32'h0);
    chk("usp_kept", 32'h0000_b000, rd);
    @(posedge core_clk_i);
    usp_wr <= 1'b1;
    usp_d <= 32'h2222_0000;
    @(posedge core_clk_i);
    usp_wr <= 1'b0;
    dbg(8'he0, 32'h0);
    chk("usp_move", 32'h2222_0000, rd);
    chk("usp_out", 32'h2222_0000, usp_o);
    dbg(8'h6f, 32'h0);
    chk("sp_active", 32'h0000_a000, rd);
    cw(4'h2, 2'b10, 32'h1234_5678);
    cw(4'h2, 2'b00, 32'h0000_00aa);
    chk("d2_byte", 32'h1234_56aa, rd_o);
    chk("d2_index", 32'h1234_56aa, ix_o);
    cw(4'h9, 2'b01, 32'h0000_8000);
    chk("a1_word", 32'hffff_8000, rd_o);
    @(posedge core_clk_i);
    bit_en <= 1'b1;
    bit_reg <= 3'h2;
    bit_num <= 5'h1f;
    bit_op <= 2'b10;
    rd_idx <= 4'h2;
    @(posedge core_clk_i);
    bit_en <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("d2_bit", 32'h9234_56aa, rd_o);
    @(posedge core_clk_i);
    mv_en <= 1'b1;
    mv_num <= 12'h801;
    mv_d <= 32'h0080_0000;
    @(posedge core_clk_i);
    mv_en <= 1'b0;
    catch(2'b01);
    chk("control_register_move_hit", 32'h1, {31'h0, hit});
    chk("control_register_move_data", 32'h0080_0000, mv_o);
    @(posedge core_clk_i);
    mv_en <= 1'b1;
    mv_num <= 12'h802;
    @(posedge core_clk_i);
    mv_en <= 1'b0;
    catch(2'b10);
    chk("control_register_move_cfg", 32'h1, {31'h0, hit});
    @(posedge core_clk_i);
    pc_ld <= 1'b1;
    pc_d <= 32'hff00_0100;
    @(posedge core_clk_i);
    pc_ld <= 1'b0;
    pc_inc <= 1'b1;
    inc_amt <= 4'h4;
    disp <= 32'h0000_0010;
    @(posedge core_clk_i);
    pc_inc <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("pc_step", 32'h0000_0104, pc_o);
    chk("pc_rel", 32'h0000_0114, rel_o);
    boot(4'h0);
    summarize();
  end

  initial begin
    repeat (4000) @(posedge core_clk_i);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
